// >>> rsc_pkg.sv
package rsc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 40;
    localparam int unsigned LONG_DELAY_NS  = 1000000;  // Supply-related release delay
    localparam int unsigned SHORT_DELAY_NS = 100000;   // Other sources release delay
    localparam int unsigned LONG_CYC       = (LONG_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SHORT_CYC      = (SHORT_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W          = 17;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 5;
    localparam logic [2:0]  IDX_CTRL = 3'h0;  // 0x00 software reset request
    localparam logic [2:0]  IDX_VM1  = 3'h1;  // 0x04 monitor 1 config
    localparam logic [2:0]  IDX_VM2  = 3'h2;  // 0x08 monitor 2 config
    localparam logic [2:0]  IDX_STAT = 3'h3;  // 0x0C sticky status, read only
    localparam logic [2:0]  IDX_CLR  = 3'h4;  // 0x10 status clear, write only
    localparam logic [2:0]  IDX_EN   = 3'h5;  // 0x14 interrupt enable
    localparam logic [2:0]  IDX_MON  = 3'h6;  // 0x18 live levels, read only
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;
    localparam int unsigned SW_RST_BIT = 0;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int unsigned ST_W    = 11;
    localparam int unsigned ST_PIN  = 0;
    localparam int unsigned ST_POR  = 1;
    localparam int unsigned ST_VM0  = 2;
    localparam int unsigned ST_VM1  = 3;  // Monitors 1, 2 reset at 3, 4
    localparam int unsigned ST_DSB  = 5;
    localparam int unsigned ST_IWDT = 6;
    localparam int unsigned ST_WDT  = 7;
    localparam int unsigned ST_SW   = 8;
    localparam int unsigned ST_INT1 = 9;  // Monitors 1, 2 interrupt at 9, 10
    localparam int unsigned NSRC    = 9;

    // Monitor 1/2 configuration, reset value all zero (disabled)
    typedef struct packed {
        logic [1:0] lvl;       // Detection level select
        logic       nmi;       // 1: non-maskable interrupt
        logic       timing;    // 0: hold until recovered, 1: pulse from detection
        logic       edge_rise; // 1: detect rise above, 0: fall below
        logic       filt_en;   // Digital filter enable
        logic [1:0] div;       // 0:/2 1:/4 2:/8 3:/16
        logic       rst_mode;  // 1: reset, 0: interrupt
        logic       en;        // Monitor enable
    } rsc_vm_cfg_s;
    localparam int unsigned CFG_W = 10;

    typedef struct packed {
        logic [1:0]              pin_s;
        logic [1:0]              por_s;
        logic [1:0]              vm0_s;
        logic [1:0][1:0]         vm_s;
        logic [1:0]              dsb_s;
        logic [2:0]              osc_s;
        logic                    dsb_prev;
        logic [1:0][3:0]         div;
        logic [1:0][1:0]         hist;
        logic [1:0]              filt;
        logic [1:0]              filt_prev;
        logic [1:0]              vm_pulse;
        logic                    strap_done;
        logic                    vm0_en;
        logic [1:0]              vm0_lvl;
        rsc_vm_cfg_s [1:0]       cfg;
        logic [ST_W-1:0]         status;
        logic [ST_W-1:0]         int_en;
        logic [NSRC-1:0]         act_prev;
        logic [CNT_W-1:0]        cnt;
        logic                    sw_req;
        logic                    sys_reset_n;
        logic                    irq;
        logic                    nmi;
        logic                    aw_got;
        logic [ADDR_W-1:0]       awaddr;
        logic                    w_got;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
    } rsc_state_s;

endpackage

// >>> rsc_top.sv
`timescale 1ns/1ps
module rsc_top
    import rsc_pkg::*;
#(
    parameter int unsigned LONG_DELAY_CYC = LONG_CYC
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ext_reset_pin_n,
    input  wire logic              supply_ok,
    input  wire logic              vm0_below,
    input  wire logic              vm1_below,
    input  wire logic              vm2_below,
    input  wire logic              low_speed_osc_clock,
    input  wire logic              dstby_wake,
    input  wire logic              iwdt_underflow,
    input  wire logic              iwdt_refresh_err,
    input  wire logic              wdt_underflow,
    input  wire logic              wdt_refresh_err,
    input  wire logic              vm0_reset_en_strap,
    input  wire logic [1:0]        vm0_level_strap,
    output logic                   sys_reset_n,
    output logic                   irq,
    output logic                   nmi,
    output logic [1:0]             vm0_level_sel,
    output logic [1:0]             vm1_level_sel,
    output logic [1:0]             vm2_level_sel,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ------------------------------------------------------------
    // Constants and helpers
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] LONG_LOAD  = CNT_W'(LONG_DELAY_CYC);
    localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(SHORT_CYC);

    // Reset image: pin high, supply seen low, other inputs idle, internal reset held, full power-on delay
    localparam rsc_state_s ST_RST = '{pin_s: 2'b11, por_s: 2'b00, cnt: LONG_LOAD, default: '0};

    // Mask of divider bits for osc divided by 2, 4, 8, 16
    function automatic logic [3:0] div_mask(input logic [1:0] sel);
        logic [3:0] m;
        m = 4'h0;
        for (int b = 0; b < 4; b++)
        begin
            if (b <= int'(sel))
            begin
                m[b] = 1'b1;
            end
        end
        return m;
    endfunction

    // True for an aligned address of a mapped register, false for others
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] <= IDX_MON);
    endfunction

    // Byte-lane merge of write data into a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    rsc_state_s q;
    rsc_state_s d;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic            osc_edge;
        logic            tick;
        logic            raw;
        logic            ev;
        logic [1:0]      vm_level;
        logic [1:0]      int_ev;
        logic [NSRC-1:0] act;
        logic            long_any;
        logic            short_any;
        logic [ST_W-1:0] clr;
        logic [ST_W-1:0] set;
        logic [ST_W-1:0] nmi_mask;
        logic [2:0]      widx;
        logic [31:0]     wv;
        osc_edge  = 1'b0;
        tick      = 1'b0;
        raw       = 1'b0;
        ev        = 1'b0;
        vm_level  = 2'b00;
        int_ev    = 2'b00;
        act       = '0;
        long_any  = 1'b0;
        short_any = 1'b0;
        clr       = '0;
        set       = '0;
        nmi_mask  = '0;
        widx      = 3'h0;
        wv        = 32'h0000_0000;
        d         = q;
        d.sw_req  = 1'b0;

        // Two-flop synchronisers for pins and analogue detectors
        d.pin_s = {q.pin_s[0], ext_reset_pin_n};
        d.por_s = {q.por_s[0], supply_ok};
        d.vm0_s = {q.vm0_s[0], vm0_below};
        d.vm_s[0] = {q.vm_s[0][0], vm1_below};
        d.vm_s[1] = {q.vm_s[1][0], vm2_below};
        d.dsb_s = {q.dsb_s[0], dstby_wake};
        d.osc_s = {q.osc_s[1:0], low_speed_osc_clock};
        d.dsb_prev = q.dsb_s[1];
        osc_edge = q.osc_s[1] & ~q.osc_s[2];

        if (!q.strap_done)
        begin
            d.strap_done = 1'b1;
            d.vm0_en     = vm0_reset_en_strap;
            d.vm0_lvl    = vm0_level_strap;
        end

        // Monitors 1 and 2: filter, edge select, mode
        for (int i = 0; i < 2; i++)
        begin
            raw  = q.vm_s[i][1];
            tick = osc_edge && ((q.div[i] & div_mask(q.cfg[i].div)) == div_mask(q.cfg[i].div));
            if (osc_edge)
            begin
                d.div[i] = q.div[i] + 4'h1;
            end
            if (!q.cfg[i].filt_en)
            begin
                d.filt[i] = raw;
            end
            else if (tick)
            begin
                d.hist[i] = {q.hist[i][0], raw};
                if ((q.hist[i][0] == raw) && (q.hist[i][1] == raw))
                begin
                    d.filt[i] = raw;
                end
            end
            d.filt_prev[i] = q.filt[i];
            ev = q.cfg[i].edge_rise ? (q.filt_prev[i] & ~q.filt[i]) : (~q.filt_prev[i] & q.filt[i]);
            vm_level[i]   = q.cfg[i].en & q.cfg[i].rst_mode & ~q.cfg[i].timing & q.filt[i];
            d.vm_pulse[i] = q.cfg[i].en & q.cfg[i].rst_mode & q.cfg[i].timing & ev;
            int_ev[i]          = q.cfg[i].en & ~q.cfg[i].rst_mode & ev;
            nmi_mask[ST_INT1+i] = q.cfg[i].nmi;
        end

        act[ST_PIN] = ~q.pin_s[1];
        act[ST_POR] = ~q.por_s[1];
        act[ST_VM0] = q.strap_done & q.vm0_en & q.vm0_s[1];
        act[ST_VM1] = vm_level[0] | q.vm_pulse[0];
        act[ST_VM1+1] = vm_level[1] | q.vm_pulse[1];
        act[ST_DSB] = q.dsb_s[1] & ~q.dsb_prev;
        act[ST_IWDT] = iwdt_underflow | iwdt_refresh_err;
        act[ST_WDT] = wdt_underflow | wdt_refresh_err;
        act[ST_SW] = q.sw_req;

        // OR of sources with release delay
        long_any  = act[ST_POR] | act[ST_VM0] | (|vm_level);
        short_any = |act;
        if (long_any)
        begin
            d.cnt = LONG_LOAD;
        end
        else if (short_any)
        begin
            d.cnt = (q.cnt < SHORT_LOAD) ? SHORT_LOAD : q.cnt;
        end
        else if (q.cnt != '0)
        begin
            d.cnt = q.cnt - CNT_W'(1);
        end
        d.sys_reset_n = ~short_any && (d.cnt == '0);
        d.act_prev    = act;

        // AXI write channels, either order
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        if (d.aw_got && d.w_got && !q.bvalid)
        begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = reg_hit(d.awaddr) ? RESP_OK : RESP_ERR;
            widx     = d.awaddr[ADDR_W-1:2];
            if (reg_hit(d.awaddr))
            begin
                case (widx)
                    IDX_CTRL:
                    begin
                        wv = merge(32'h0000_0000, d.wdata, d.wstrb);
                        d.sw_req = wv[SW_RST_BIT];
                    end
                    IDX_VM1:
                    begin
                        wv = merge(32'(q.cfg[0]), d.wdata, d.wstrb);
                        d.cfg[0] = wv[CFG_W-1:0];
                    end
                    IDX_VM2:
                    begin
                        wv = merge(32'(q.cfg[1]), d.wdata, d.wstrb);
                        d.cfg[1] = wv[CFG_W-1:0];
                    end
                    IDX_CLR:
                    begin
                        wv  = merge(32'h0000_0000, d.wdata, d.wstrb);
                        clr = wv[ST_W-1:0];
                    end
                    IDX_EN:
                    begin
                        wv = merge(32'(q.int_en), d.wdata, d.wstrb);
                        d.int_en = wv[ST_W-1:0];
                    end
                    default:
                    begin
                        wv = 32'h0000_0000;
                    end
                endcase
            end
        end
        d.awready = ~d.aw_got & ~d.bvalid;
        d.wready  = ~d.w_got & ~d.bvalid;

        // Sticky status: new events win over clear
        set = {int_ev, act & ~q.act_prev};
        d.status = (q.status & ~clr) | set;
        d.irq    = |(d.status & d.int_en & ~nmi_mask);
        d.nmi    = |(d.status & nmi_mask);

        // AXI read channel
        if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rresp  = reg_hit(s_axi_araddr) ? RESP_OK : RESP_ERR;
            case (s_axi_araddr[ADDR_W-1:2])
                IDX_VM1:  d.rdata = 32'(q.cfg[0]);
                IDX_VM2:  d.rdata = 32'(q.cfg[1]);
                IDX_STAT: d.rdata = 32'(q.status);
                IDX_EN:   d.rdata = 32'(q.int_en);
                IDX_MON:  d.rdata = 32'({~q.sys_reset_n, q.filt, q.vm0_s[1], q.por_s[1], q.pin_s[1]});
                default:  d.rdata = 32'h0000_0000;
            endcase
            if (!reg_hit(s_axi_araddr))
            begin
                d.rdata = 32'h0000_0000;
            end
        end
        d.arready = ~d.rvalid;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= ST_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from state flops
    assign sys_reset_n   = q.sys_reset_n;
    assign irq           = q.irq;
    assign nmi           = q.nmi;
    assign vm0_level_sel = q.vm0_lvl;
    assign vm1_level_sel = q.cfg[0].lvl;
    assign vm2_level_sel = q.cfg[1].lvl;
    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

endmodule

// >>> rsc_assertions.sv
`timescale 1ns/1ps
module rsc_assertions
    import rsc_pkg::*;
#(
    parameter int unsigned LONG_DELAY_CYC = LONG_CYC
)(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              ext_reset_pin_n,
    input wire logic              supply_ok,
    input wire logic              vm0_below,
    input wire logic              dstby_wake,
    input wire logic              iwdt_underflow,
    input wire logic              iwdt_refresh_err,
    input wire logic              wdt_underflow,
    input wire logic              wdt_refresh_err,
    input wire logic              vm0_reset_en_strap,
    input wire logic              sys_reset_n,
    input wire logic              irq,
    input wire logic              nmi,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [16:0] por_q, wd_q;
    logic        wd_src;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Any watchdog event in this cycle
    assign wd_src = iwdt_underflow | iwdt_refresh_err | wdt_underflow | wdt_refresh_err;

    // Good-supply age and age of the last watchdog event
    always_ff @(posedge aclk)
    begin
        por_q <= (!aresetn || !supply_ok) ? 17'h0_0000 : (por_q < LONG_DELAY_CYC) ? por_q + 17'h0_0001 : por_q;
        wd_q  <= !aresetn ? 17'(SHORT_CYC) : wd_src ? 17'h0_0000 : (wd_q < SHORT_CYC) ? wd_q + 17'h0_0001 : wd_q;
    end

    // ------------------------------------------------------------
    // Source checks
    // ------------------------------------------------------------
    // pin holds reset
    AST_PIN_HOLD: assert property (!ext_reset_pin_n [*4] |-> !sys_reset_n)
        else $error("pin low, reset released");
    AST_SUPPLY_LOW: assert property (!supply_ok [*4] |-> !sys_reset_n)
        else $error("supply low, reset released");
    AST_POR_DELAY: assert property ((por_q > 3 && por_q < LONG_DELAY_CYC) |-> !sys_reset_n)
        else $error("early supply release");
    AST_VM0: assert property ((vm0_reset_en_strap && vm0_below) [*4] |-> !sys_reset_n)
        else $error("monitor 0 low, no reset");
    AST_IWDT: assert property ((iwdt_underflow || iwdt_refresh_err) |=> !sys_reset_n)
        else $error("iwdt event, no reset");
    AST_WDT: assert property ((wdt_underflow || wdt_refresh_err) |=> !sys_reset_n)
        else $error("wdt event, no reset");
    AST_SW: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == {IDX_CTRL, 2'b00} && s_axi_wstrb[0] && s_axi_wdata[0]) |-> ##[1:3] !sys_reset_n)
        else $error("sw request, no reset");
    AST_DSB: assert property ($rose(dstby_wake) |-> ##[2:5] !sys_reset_n)
        else $error("wake, no reset");
    AST_SHORT_HOLD: assert property ((wd_q < SHORT_CYC - 2) |-> !sys_reset_n)
        else $error("early short release");

    // Main scenarios reached
    COV_RELEASE: cover property ($rose(sys_reset_n));
    COV_IRQ: cover property ($rose(irq));
    COV_NMI: cover property ($rose(nmi));
endmodule

bind rsc_top rsc_assertions #(.LONG_DELAY_CYC(LONG_DELAY_CYC)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .ext_reset_pin_n(ext_reset_pin_n), .supply_ok(supply_ok),
    .vm0_below(vm0_below), .dstby_wake(dstby_wake), .iwdt_underflow(iwdt_underflow),
    .iwdt_refresh_err(iwdt_refresh_err), .wdt_underflow(wdt_underflow), .wdt_refresh_err(wdt_refresh_err),
    .vm0_reset_en_strap(vm0_reset_en_strap), .sys_reset_n(sys_reset_n), .irq(irq), .nmi(nmi),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready));

// >>> rsc_partner.sv
`timescale 1ns/1ps
module rsc_partner
#(
    parameter int SETTLE_NS = 3
)(
    input  wire logic       pin_lo,
    input  wire logic       supply_dn,
    input  wire logic [2:0] below,
    output logic            ext_reset_pin_n,
    output logic            supply_ok,
    output logic [2:0]      vm_below,
    output logic            low_speed_osc_clock
);
    // Analogue outputs settle a little after each request
    assign #(SETTLE_NS) ext_reset_pin_n = !pin_lo;
    assign #(SETTLE_NS) supply_ok = !supply_dn;
    assign #(SETTLE_NS) vm_below = below;

    // Free-running slow oscillator, period 200 ns
    initial
    begin
        low_speed_osc_clock = 1'b0;
        forever #100 low_speed_osc_clock = ~low_speed_osc_clock;
    end
endmodule

// >>> reset_source_combiner_bench.sv
`timescale 1ns/1ps
module reset_source_combiner_bench
    import rsc_pkg::*;
;
    localparam int LD = 20;
    typedef struct {int s; int b; int d;} rsc_row_s;

    logic        aclk, aresetn, pin_lo, supply_dn, pin_n, sup_ok, osc, dsb, strap_en;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic        sys_reset_n, irq, nmi;
    logic [1:0]  bresp, rresp, r, l0, l1, l2;
    logic [2:0]  below, vm_b;
    logic [3:0]  wd, wstrb;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    int          n, failures, samples_checked;
    rsc_row_s    rows [9] = '{'{0, ST_PIN, SHORT_CYC}, '{1, ST_IWDT, SHORT_CYC}, '{2, ST_IWDT, SHORT_CYC},
        '{3, ST_WDT, SHORT_CYC}, '{4, ST_WDT, SHORT_CYC}, '{5, ST_DSB, SHORT_CYC}, '{6, ST_SW, SHORT_CYC},
        '{7, ST_VM0, LD}, '{8, ST_POR, LD}};

    rsc_partner PARTNER (.pin_lo(pin_lo), .supply_dn(supply_dn), .below(below), .ext_reset_pin_n(pin_n),
        .supply_ok(sup_ok), .vm_below(vm_b), .low_speed_osc_clock(osc));

    rsc_top #(.LONG_DELAY_CYC(LD)) DUT (.aclk(aclk), .aresetn(aresetn), .ext_reset_pin_n(pin_n),
        .supply_ok(sup_ok), .vm0_below(vm_b[0]), .vm1_below(vm_b[1]), .vm2_below(vm_b[2]),
        .low_speed_osc_clock(osc), .dstby_wake(dsb), .iwdt_underflow(wd[0]), .iwdt_refresh_err(wd[1]),
        .wdt_underflow(wd[2]), .wdt_refresh_err(wd[3]), .vm0_reset_en_strap(strap_en),
        .vm0_level_strap(2'h2), .sys_reset_n(sys_reset_n), .irq(irq), .nmi(nmi), .vm0_level_sel(l0),
        .vm1_level_sel(l1), .vm2_level_sel(l2), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge aclk);
    endtask

    task automatic wait_rel();
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 9000)
        begin
            @(posedge aclk);
            n++;
        end
    endtask

    task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [4:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic src(input int s, input logic v);
        case (s)
            0: pin_lo <= v;
            5: dsb <= v;
            6: if (v) axi_wr({IDX_CTRL, 2'b00}, 32'h0000_0001);
            7: below[0] <= v;
            8: supply_dn <= v;
            default: wd[s-1] <= v;
        endcase
    endtask

    task automatic clr_st();
        axi_wr({IDX_CLR, 2'b00}, 32'h0000_07FF);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    initial
    begin
        #(25 * 50000);
        failures++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {aresetn, pin_lo, supply_dn, below, dsb, wd, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, failures, samples_checked} = '0;
        strap_en = 1'b1;
        tick(16);
        aresetn <= 1'b1;
        tick(1);
        check("por_low", sys_reset_n, 1'b0);
        wait_rel();
        check("por_delay", n >= LD && n <= LD + 6, 1'b1);
        check("vm0_level", l0, 2'h2);
        axi_rd({IDX_VM1, 2'b00});
        check("vm1_cfg_reset", d, 32'h0000_0000);
        axi_rd(5'h1C);
        check("rd_unmapped", r, RESP_ERR);
        axi_wr(5'h1C, 32'h0000_0001);
        check("wr_unmapped", r, RESP_ERR);
        $display("test reset done");
        foreach (rows[i])
        begin
            src(rows[i].s, 1'b1);
            tick(6);
            check("source_reset", sys_reset_n, 1'b0);
            src(rows[i].s, 1'b0);
            wait_rel();
            check("release_delay", n >= rows[i].d - 12 && n <= rows[i].d + 8, 1'b1);
            axi_rd({IDX_STAT, 2'b00});
            check("status_bit", d[rows[i].b], 1'b1);
            clr_st();
            $display("test source %0d done", rows[i].s);
        end
        axi_wr({IDX_EN, 2'b00}, 32'h0000_0200);
        axi_wr({IDX_VM1, 2'b00}, 32'h0000_0001);
        below[1] <= 1'b1;
        tick(12);
        check("irq", irq, 1'b1);
        check("no_reset", sys_reset_n, 1'b1);
        axi_wr({IDX_EN, 2'b00}, 32'h0000_0000);
        tick(3);
        check("irq_masked", irq, 1'b0);
        clr_st();
        axi_wr({IDX_EN, 2'b00}, 32'h0000_0200);
        below[1] <= 1'b0;
        tick(3);
        check("irq_cleared", irq, 1'b0);
        axi_wr({IDX_VM2, 2'b00}, 32'h0000_0181);
        check("vm2_level", l2, 2'h1);
        below[2] <= 1'b1;
        tick(12);
        check("nmi", nmi, 1'b1);
        check("nmi_not_irq", irq, 1'b0);
        below[2] <= 1'b0;
        axi_wr({IDX_VM2, 2'b00}, 32'h0000_0000);
        clr_st();
        $display("test interrupts done");
        axi_wr({IDX_VM1, 2'b00}, 32'h0000_0021);
        below[1] <= 1'b1;
        tick(12);
        check("rise_quiet", irq, 1'b0);
        below[1] <= 1'b0;
        tick(12);
        check("rise_seen", irq, 1'b1);
        clr_st();
        axi_wr({IDX_VM1, 2'b00}, 32'h0000_001D);
        below[1] <= 1'b1;
        tick(20);
        below[1] <= 1'b0;
        tick(300);
        check("glitch_filtered", irq, 1'b0);
        below[1] <= 1'b1;
        tick(600);
        check("filtered_event", irq, 1'b1);
        below[1] <= 1'b0;
        tick(600);
        clr_st();
        $display("test detection done");
        axi_wr({IDX_VM1, 2'b00}, 32'h0000_0203);
        check("vm1_level", l1, 2'h2);
        below[1] <= 1'b1;
        tick(50);
        check("hold_reset", sys_reset_n, 1'b0);
        below[1] <= 1'b0;
        wait_rel();
        check("hold_release", n >= LD && n <= LD + 8, 1'b1);
        axi_wr({IDX_VM1, 2'b00}, 32'h0000_0243);
        below[1] <= 1'b1;
        tick(10);
        check("pulse_reset", sys_reset_n, 1'b0);
        wait_rel();
        check("pulse_release", n >= SHORT_CYC - 20 && n <= SHORT_CYC + 8, 1'b1);
        below[1] <= 1'b0;
        $display("test release timing done");
        end_of_test();
    end
endmodule
